// File: core/lcrc_bank.sv
// register bank for loop compensation codes and internal regulator level
`timescale 1ns/1ns
// How it works
// - loop word uses five-byte block transfers
// - conversion off: written codes reach loop at once
// - conversion on: store write, hold loop codes
// - current integ cap: low 39:38, high 25:24
// - current filter cap code at 37:33
// - bit 32 doubles current integ cap
// - current gain resistor code at 31:26
// - voltage integ cap: low 23:22, high 9:8
// - voltage filter cap code at 21:17
// - voltage gain resistor code at 15:10
// - transconductance codes at 5:4 and 1:0
// - loop word default from nvm or straps
// - power stage uses one-byte block transfers
// - power stage applies within one millisecond
// - bits 7:4 pick regulator level 0h..Fh; codes outside 3h..Ah are flagged
// - power stage bits 3:0 read zero
module lcrc_bank import lcrc_pkg::*; #(
	parameter int STAGE_CYCLES = LCRC_STAGE_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// block command port from the bus engine
	input wire logic cmd_wr_stb,
	input wire logic cmd_rd_stb,
	input wire logic [7:0] cmd_code,
	input wire logic [3:0] cmd_byte_count,
	input wire logic [39:0] cmd_wr_data,
	output logic [39:0] cmd_rd_data,
	output logic [3:0] cmd_rd_count,
	output logic cmd_ack,
	output logic cmd_invalid,
	// default load from nonvolatile store or strap detect, and restore
	input wire logic [39:0] comp_default,
	input wire logic [7:0] stage_default,
	input wire logic load_defaults,
	// converter state, from another clock domain
	input wire logic conversion_enable,
	// loop and regulator outputs
	output lcrc_loop_codes_t loop_codes,
	output logic [3:0] regulator_level_code,
	output logic level_invalid,
	output logic stage_busy
);
	logic rst_meta_reg, rst_sync_reg;
	logic conv_meta_reg, conv_reg;
	logic [39:0] comp_reg, comp_next;
	logic [3:0] lvl_reg, lvl_next;
	lcrc_loop_codes_t live_reg, live_next;
	logic [3:0] live_lvl_reg, live_lvl_next;
	logic lvl_bad_reg, lvl_bad_next;
	logic [39:0] rd_reg, rd_next;
	logic [3:0] rdc_reg, rdc_next;
	logic ack_reg, ack_next;
	logic inv_reg, inv_next;
	logic [31:0] busy_cnt_reg, busy_cnt_next;
	logic busy_reg, busy_next;
	logic boot_reg, boot_next;

	function automatic lcrc_loop_codes_t unpack_comp(input logic [39:0] w);
		lcrc_loop_codes_t c;
		c.current_integ_cap_code = {w[CZI_HI_MSB:CZI_HI_LSB], w[CZI_LO_MSB:CZI_LO_LSB]};
		c.current_filter_cap_code = w[CPI_MSB:CPI_LSB];
		c.current_integ_cap_doubler = w[CZI_MUL_BIT];
		c.current_gain_res_code = w[RVI_MSB:RVI_LSB];
		c.voltage_integ_cap_code = {w[CZV_HI_MSB:CZV_HI_LSB], w[CZV_LO_MSB:CZV_LO_LSB]};
		c.voltage_filter_cap_code = w[CPV_MSB:CPV_LSB];
		c.voltage_gain_res_code = w[RVV_MSB:RVV_LSB];
		c.voltage_transcond_code = w[GMV_MSB:GMV_LSB];
		c.current_transcond_code = w[GMI_MSB:GMI_LSB];
		return c;
	endfunction

	// reset release and enable synchronisers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			conv_meta_reg <= 1'b0;
			conv_reg <= 1'b0;
		end else begin
			conv_meta_reg <= conversion_enable;
			conv_reg <= conv_meta_reg;
		end
	end

	always_comb begin
		comp_next = comp_reg;
		lvl_next = lvl_reg;
		live_next = live_reg;
		live_lvl_next = live_lvl_reg;
		rd_next = rd_reg;
		rdc_next = rdc_reg;
		ack_next = 1'b0;
		inv_next = 1'b0;
		busy_cnt_next = busy_cnt_reg;
		busy_next = busy_reg;
		boot_next = 1'b0;
		if (busy_cnt_reg != 32'h0000_0000) begin
			busy_cnt_next = busy_cnt_reg - 32'h0000_0001;
		end else begin
			busy_next = 1'b0;
		end
		// defaults come from the store, at first release and on restore
		if (boot_reg || load_defaults) begin
			comp_next = comp_default;
			lvl_next = stage_default[LVL_MSB:LVL_LSB];
			live_next = unpack_comp(comp_default);
			live_lvl_next = stage_default[LVL_MSB:LVL_LSB];
		end else if (cmd_wr_stb) begin
			ack_next = 1'b1;
			if (cmd_code == LCRC_CMD_LOOP_COMP &&
				cmd_byte_count == 4'(LCRC_COMP_BYTES)) begin
				// reserved bits are stored as sent; host keeps them zero
				comp_next = cmd_wr_data;
				if (!conv_reg) begin
					live_next = unpack_comp(cmd_wr_data);
				end
				// while converting the live codes stay put
			end else if (cmd_code == LCRC_CMD_POWER_STAGE &&
				cmd_byte_count == 4'(LCRC_STAGE_BYTES)) begin
				lvl_next = cmd_wr_data[LVL_MSB:LVL_LSB];
				live_lvl_next = cmd_wr_data[LVL_MSB:LVL_LSB];
				busy_next = 1'b1;
				busy_cnt_next = 32'(STAGE_CYCLES - 1);
			end else begin
				inv_next = 1'b1;
			end
		end else if (cmd_rd_stb) begin
			ack_next = 1'b1;
			if (cmd_code == LCRC_CMD_LOOP_COMP) begin
				rd_next = comp_reg;
				rdc_next = 4'(LCRC_COMP_BYTES);
			end else if (cmd_code == LCRC_CMD_POWER_STAGE) begin
				rd_next = {32'h0000_0000, lvl_reg, LCRC_RST_NIB};
				rdc_next = 4'(LCRC_STAGE_BYTES);
			end else begin
				rd_next = 40'h00_0000_0000;
				rdc_next = 4'h0;
				inv_next = 1'b1;
			end
		end
		// codes outside the valid window are flagged, not masked
		lvl_bad_next = (live_lvl_next < LCRC_LVL_MIN) || (live_lvl_next > LCRC_LVL_MAX);
	end

	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			comp_reg <= 40'h00_0000_0000;
			lvl_reg <= 4'h0;
			live_reg <= '0;
			live_lvl_reg <= 4'h0;
			lvl_bad_reg <= 1'b1;
			rd_reg <= 40'h00_0000_0000;
			rdc_reg <= 4'h0;
			ack_reg <= 1'b0;
			inv_reg <= 1'b0;
			busy_cnt_reg <= 32'h0000_0000;
			busy_reg <= 1'b0;
			boot_reg <= 1'b1;
		end else begin
			comp_reg <= comp_next;
			lvl_reg <= lvl_next;
			live_reg <= live_next;
			live_lvl_reg <= live_lvl_next;
			lvl_bad_reg <= lvl_bad_next;
			rd_reg <= rd_next;
			rdc_reg <= rdc_next;
			ack_reg <= ack_next;
			inv_reg <= inv_next;
			busy_cnt_reg <= busy_cnt_next;
			busy_reg <= busy_next;
			boot_reg <= boot_next;
		end
	end

	assign cmd_rd_data = rd_reg;
	assign cmd_rd_count = rdc_reg;
	assign cmd_ack = ack_reg;
	assign cmd_invalid = inv_reg;
	assign loop_codes = live_reg;
	assign regulator_level_code = live_lvl_reg;
	assign level_invalid = lvl_bad_reg;
	assign stage_busy = busy_reg;
endmodule

// File: core/lcrc_pkg.sv
// package: command codes, field layouts and timing for the loop and regulator config bank
package lcrc_pkg;
	localparam logic [7:0] LCRC_CMD_LOOP_COMP = 8'hB1;
	localparam logic [7:0] LCRC_CMD_POWER_STAGE = 8'hB5;
	localparam int LCRC_COMP_BYTES = 5;
	localparam int LCRC_STAGE_BYTES = 1;
	// compensation word field positions
	localparam int CZI_LO_MSB = 39;
	localparam int CZI_LO_LSB = 38;
	localparam int CPI_MSB = 37;
	localparam int CPI_LSB = 33;
	localparam int CZI_MUL_BIT = 32;
	localparam int RVI_MSB = 31;
	localparam int RVI_LSB = 26;
	localparam int CZI_HI_MSB = 25;
	localparam int CZI_HI_LSB = 24;
	localparam int CZV_LO_MSB = 23;
	localparam int CZV_LO_LSB = 22;
	localparam int CPV_MSB = 21;
	localparam int CPV_LSB = 17;
	localparam int RVV_MSB = 15;
	localparam int RVV_LSB = 10;
	localparam int CZV_HI_MSB = 9;
	localparam int CZV_HI_LSB = 8;
	localparam int GMV_MSB = 5;
	localparam int GMV_LSB = 4;
	localparam int GMI_MSB = 1;
	localparam int GMI_LSB = 0;
	// reserved bits of the compensation word, kept as written
	localparam logic [39:0] LCRC_COMP_RSVD_MASK = 40'h00_0001_00CC;
	// power stage field
	localparam int LVL_MSB = 7;
	localparam int LVL_LSB = 4;
	localparam logic [3:0] LCRC_LVL_MIN = 4'h3;
	localparam logic [3:0] LCRC_LVL_MAX = 4'hA;
	// settle time for a power stage write
	localparam int LCRC_STAGE_MAX_US = 1000;
	localparam int LCRC_CLK_MHZ = 20;
	localparam int LCRC_STAGE_CYCLES = LCRC_STAGE_MAX_US * LCRC_CLK_MHZ;
	localparam logic [3:0] LCRC_RST_NIB = 4'h0;

	typedef struct packed {
		logic [3:0] current_integ_cap_code;
		logic [4:0] current_filter_cap_code;
		logic current_integ_cap_doubler;
		logic [5:0] current_gain_res_code;
		logic [3:0] voltage_integ_cap_code;
		logic [4:0] voltage_filter_cap_code;
		logic [5:0] voltage_gain_res_code;
		logic [1:0] voltage_transcond_code;
		logic [1:0] current_transcond_code;
	} lcrc_loop_codes_t;
endpackage

// File: sim/lcrc_bank_chk.sv
// assertion checker for the loop and regulator config bank
`timescale 1ns/1ns
module lcrc_chk import lcrc_pkg::*; #(
	parameter int STAGE_CYCLES = LCRC_STAGE_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// command port
	input wire logic cmd_wr_stb,
	input wire logic cmd_rd_stb,
	input wire logic [7:0] cmd_code,
	input wire logic [3:0] cmd_byte_count,
	input wire logic [39:0] cmd_wr_data,
	input wire logic [39:0] cmd_rd_data,
	input wire logic [3:0] cmd_rd_count,
	input wire logic cmd_ack,
	// control and live outputs
	input wire logic load_defaults,
	input wire logic conversion_enable,
	input lcrc_loop_codes_t loop_codes,
	input wire logic [3:0] regulator_level_code,
	input wire logic level_invalid,
	input wire logic stage_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire logic go = (cmd_wr_stb || cmd_rd_stb) && !load_defaults;
	wire logic lw = go && cmd_wr_stb && cmd_code == 8'hB1 && cmd_byte_count == 4'h5;
	wire logic sw = go && cmd_wr_stb && cmd_code == 8'hB5 && cmd_byte_count == 4'h1;
	wire logic rd = go && !cmd_wr_stb;
	logic [15:0] bc_reg;
	logic [15:0] bc_next;
	function automatic lcrc_loop_codes_t fmap(input logic [39:0] d);
		return {d[25:24], d[39:38], d[37:26], d[9:8], d[23:22], d[21:17], d[15:10], d[5:4],
			d[1:0]};
	endfunction
	// busy length counted here since the limit is far beyond a delay range
	always_comb bc_next = stage_busy ? bc_reg + 16'h0001 : 16'h0000;
	always_ff @(posedge ref_clk or negedge nrst) bc_reg <= !nrst ? 16'h0000 : bc_next;
	a_ack_follows: assert property (go |=> cmd_ack) else $error("no ack");
	a_ack_cause: assert property (cmd_ack |-> $past(go)) else $error("stray ack");
	a_loop_apply: assert property ((!conversion_enable)[*4] ##0 lw |=>
		loop_codes == fmap($past(cmd_wr_data))) else $error("loop not applied");
	a_loop_hold: assert property (conversion_enable[*4] ##0 !load_defaults |=>
		$stable(loop_codes)) else $error("loop changed");
	a_level_flag: assert property (level_invalid == (regulator_level_code < 4'h3 ||
		regulator_level_code > 4'hA)) else $error("level flag");
	a_stage_apply: assert property (sw |=> stage_busy &&
		regulator_level_code == $past(cmd_wr_data[7:4])) else $error("stage");
	a_busy_bound: assert property (bc_reg <= STAGE_CYCLES) else $error("busy long");
	a_stage_read: assert property (rd && cmd_code == 8'hB5 |=> cmd_rd_count == 4'h1 &&
		cmd_rd_data[3:0] == 4'h0) else $error("stage read");
	a_loop_read: assert property (rd && cmd_code == 8'hB1 |=> cmd_rd_count == 4'h5)
		else $error("loop read");
	cover property (lw);
	cover property (sw);
	cover property (conversion_enable && lw);
endmodule
bind lcrc_bank lcrc_chk #(.STAGE_CYCLES(STAGE_CYCLES)) chk (.*);

// File: sim/lcrc_host.sv
// host model issuing block transfers to the config bank
`timescale 1ns/1ns
module lcrc_host import lcrc_pkg::*; (
	// clock
	input wire logic ref_clk,
	// requests
	output logic cmd_wr_stb,
	output logic cmd_rd_stb,
	output logic [7:0] cmd_code,
	output logic [3:0] cmd_byte_count,
	output logic [39:0] cmd_wr_data,
	output logic load_defaults,
	// answers
	input wire logic [39:0] cmd_rd_data,
	input wire logic [3:0] cmd_rd_count,
	input wire logic cmd_ack,
	input wire logic cmd_invalid
);
	logic [39:0] rd_q;
	logic [3:0] cnt_q;
	logic ack_q;
	logic inv_q;
	initial {cmd_wr_stb, cmd_rd_stb, load_defaults, cmd_code, cmd_byte_count, cmd_wr_data} = 55'h0;
	task automatic xfer(input logic w, input logic [7:0] c, input logic [3:0] n,
		input logic [39:0] d);
		@(posedge ref_clk);
		#1;
		{cmd_wr_stb, cmd_rd_stb, cmd_code, cmd_byte_count} = {w, !w, c, n};
		cmd_wr_data = c == LCRC_CMD_LOOP_COMP ? d & ~LCRC_COMP_RSVD_MASK : d;
		@(posedge ref_clk);
		#1;
		{cmd_wr_stb, cmd_rd_stb} = 2'h0;
		{ack_q, inv_q, cnt_q, rd_q} = {cmd_ack, cmd_invalid, cmd_rd_count, cmd_rd_data};
	endtask
	// restore stands in for the store, override clear and restore sequence
	task automatic restore();
		@(posedge ref_clk);
		#1;
		load_defaults = 1'b1;
		@(posedge ref_clk);
		#1;
		load_defaults = 1'b0;
	endtask
endmodule

// File: sim/tb_top.sv
// self-checking bench for the loop and regulator config bank
`timescale 1ns/1ns
module tb_top import lcrc_pkg::*; ;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic conversion_enable = 1'b0;
	logic [39:0] comp_default = 40'h00_0000_0001;
	logic [7:0] stage_default = 8'h50;
	logic cmd_wr_stb, cmd_rd_stb, load_defaults, cmd_ack, cmd_invalid, level_invalid, stage_busy;
	logic [7:0] cmd_code;
	logic [3:0] cmd_byte_count, cmd_rd_count, regulator_level_code;
	logic [39:0] cmd_wr_data, cmd_rd_data;
	lcrc_loop_codes_t loop_codes;
	int err_total = 0;
	int total_checks = 0;
	lcrc_bank #(.STAGE_CYCLES(8)) dut (.*);
	lcrc_host host (.*);
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	task automatic end_sim();
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial forever #25 ref_clk = ~ref_clk;
	initial begin
		#200000;
		err_total++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		#1;
		nrst = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		chk(loop_codes === 35'h0_0000_0001 && regulator_level_code === 4'h5, "boot");
		host.xfer(1'b1, LCRC_CMD_LOOP_COMP, 4'h5, 40'h40_0200_0301);
		chk(host.ack_q === 1'b1 && loop_codes === 35'h4_8006_0001, "apply");
		host.xfer(1'b0, LCRC_CMD_LOOP_COMP, 4'h0, 40'h00_0000_0000);
		chk(host.rd_q === 40'h40_0200_0301 && host.cnt_q === 4'h5, "readback");
		host.xfer(1'b1, LCRC_CMD_LOOP_COMP, 4'h4, 40'h00_0000_0000);
		chk(host.inv_q === 1'b1 && loop_codes === 35'h4_8006_0001, "short write");
		host.xfer(1'b0, 8'hB2, 4'h0, 40'h00_0000_0000);
		chk(host.inv_q === 1'b1 && host.cnt_q === 4'h0, "bad code");
		conversion_enable = 1'b1;
		repeat (4) @(posedge ref_clk);
		host.xfer(1'b1, LCRC_CMD_LOOP_COMP, 4'h5, 40'h00_0000_0030);
		repeat (3) @(posedge ref_clk);
		chk(loop_codes === 35'h4_8006_0001, "blocked");
		host.xfer(1'b0, LCRC_CMD_LOOP_COMP, 4'h0, 40'h00_0000_0000);
		chk(host.rd_q === 40'h00_0000_0030, "stored");
		// all 16 level codes 0h..Fh are swept here only because the bench feeds no real regulator node
		for (int c = 0; c < 16; c++) begin
			host.xfer(1'b1, LCRC_CMD_POWER_STAGE, 4'h1, {32'h0000_0000, c[3:0], 4'hF});
			chk(regulator_level_code === c[3:0] && stage_busy === 1'b1, "level");
			chk(level_invalid === (c < 3 || c > 10), "level flag");
			repeat (8) @(posedge ref_clk);
			#1;
			chk(stage_busy === 1'b0, "busy");
			host.xfer(1'b0, LCRC_CMD_POWER_STAGE, 4'h0, 40'h00_0000_0000);
			chk(host.rd_q[7:0] === {c[3:0], 4'h0} && host.cnt_q === 4'h1, "stage rd");
		end
		host.restore();
		repeat (2) @(posedge ref_clk);
		chk(loop_codes === 35'h0_0000_0001 && regulator_level_code === 4'h5, "restore");
		end_sim();
	end
endmodule
